/* File: rtl/iol_map.svh */
// register offsets, reset values and sizes of the io line output block
`ifndef IOL_MAP_SVH
`define IOL_MAP_SVH
`define IOL_NLINES 32
// byte offsets on the register bus, one aligned word each
`define IOL_OFF_OWN_CLAIM 8'h00
`define IOL_OFF_OWN_RELEASE 8'h04
`define IOL_OFF_OWN_STATE 8'h08
`define IOL_OFF_DRIVE_ON 8'h10
`define IOL_OFF_DRIVE_OFF 8'h14
`define IOL_OFF_DRIVE_STATE 8'h18
`define IOL_OFF_LEVEL_HIGH 8'h30
`define IOL_OFF_LEVEL_LOW 8'h34
`define IOL_OFF_LEVEL_VALUE 8'h38
`define IOL_OFF_PIN_LEVEL 8'h3C
`define IOL_OFF_OD_ON 8'h50
`define IOL_OFF_OD_OFF 8'h54
`define IOL_OFF_OD_STATE 8'h58
`define IOL_OFF_PU_OFF 8'h60
`define IOL_OFF_PU_ON 8'h64
`define IOL_OFF_PU_STATE 8'h68
`define IOL_OFF_SEL_LOW 8'h70
`define IOL_OFF_SEL_HIGH 8'h74
`define IOL_OFF_PD_OFF 8'h90
`define IOL_OFF_PD_ON 8'h94
`define IOL_OFF_PD_STATE 8'h98
`define IOL_OFF_MASK_ON 8'hA0
`define IOL_OFF_MASK_OFF 8'hA4
`define IOL_OFF_MASK_STATE 8'hA8
// reset values
`define IOL_RST_PULLUP 32'h0000_0000
`define IOL_RST_PULLDOWN 32'hFFFF_FFFF
`define IOL_RST_ZERO 32'h0000_0000
`define IOL_RST_ONES 32'hFFFF_FFFF
`endif

/* File: rtl/iol_pkg.sv */
// types shared by the io line output block
`default_nettype none
package iol_pkg;
`include "iol_map.svh"
  typedef logic [`IOL_NLINES-1:0] iol_word_t;
  typedef struct packed {
    logic [7:0] address;
    logic read;
    logic write;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } iol_avm_req_t;
  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } iol_avm_rsp_t;
  typedef struct packed {
    iol_word_t out;
    iol_word_t oe;
  } iol_periph_drv_t;
  typedef struct packed {
    iol_word_t a;
    iol_word_t b;
    iol_word_t c;
    iol_word_t d;
  } iol_periph_in_t;
  typedef struct packed {
    iol_word_t out;
    iol_word_t oe_n;
    iol_word_t pu_en;
    iol_word_t pd_en;
  } iol_pad_drv_t;
  typedef struct packed {
    iol_word_t own;
    iol_word_t sel_lo;
    iol_word_t sel_hi;
    iol_word_t drive;
    iol_word_t level;
    iol_word_t mask;
    iol_word_t pu;
    iol_word_t pd;
    iol_word_t md;
    iol_word_t sync1;
    iol_word_t sync2;
    iol_word_t pin_level;
    logic waitreq;
    logic [31:0] rdata;
    iol_pad_drv_t pad;
    iol_periph_in_t fan;
  } iol_state_t;
endpackage
`default_nettype wire

/* File: rtl/iol_top.sv */
// io line control: pulls, peripheral muxing, output drive and open drain
//
// Functional notes
// - pull-up off write sets status, on clears
// - pull-down status, zero means active
// - pull-down enable ignored while pull-up on
// - pull-up enable ignored while pull-down on
// - pull-up works for any line owner
// - reset: pull-ups on, pull-downs off
// - ownership set by claim, cleared by release
// - unmuxed lines ignore ownership writes, read one
// - ownership reset value is a parameter
// - select code picks peripheral a to d
// - pin input reaches all four peripherals
// - selects reset zero, write regardless of owner
// - released line drives from selected peripheral
// - drive status set and cleared by writes
// - level set and clear registers change output
// - drive and level update while peripheral owns
// - direct level write touches masked bits only
// - mask set and cleared, resets zero
// - open drain drives low only
// - open drain set and clear, resets zero
// - writes work while line clock gated
`timescale 1ns/1ps
`default_nettype none
`include "iol_map.svh"

module iol_top import iol_pkg::*; #(
  parameter iol_word_t MUX_PRESENT = `IOL_RST_ONES,
  parameter iol_word_t OWN_RESET = `IOL_RST_ONES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // avalon register slave
  input wire iol_avm_req_t avm_req,
  output var iol_avm_rsp_t avm_rsp,
  // controller clock gate for pin sampling
  input wire logic line_clk_en,
  // pads
  input wire iol_word_t pad_in,
  output var iol_pad_drv_t pad_drv,
  // peripheral functions a..d
  input wire iol_periph_drv_t [3:0] periph_drv,
  output var iol_periph_in_t periph_in
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // byte enables widened to a bit mask
  function automatic logic [31:0] be_mask(input logic [3:0] be);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int b = 0; b < 4; b++) begin
      m[b*8 +: 8] = {8{be[b]}};
    end
    return m;
  endfunction

  // replace only the bits chosen by m
  function automatic iol_word_t merge(input iol_word_t cur, input iol_word_t nw,
                                      input iol_word_t m);
    return (cur & ~m) | (nw & m);
  endfunction

  // reset image: constants and parameters only
  localparam iol_state_t RST_ST = '{
    own: OWN_RESET,
    sel_lo: `IOL_RST_ZERO,
    sel_hi: `IOL_RST_ZERO,
    drive: `IOL_RST_ZERO,
    level: `IOL_RST_ZERO,
    mask: `IOL_RST_ZERO,
    pu: `IOL_RST_PULLUP,
    pd: `IOL_RST_PULLDOWN,
    md: `IOL_RST_ZERO,
    sync1: `IOL_RST_ZERO,
    sync2: `IOL_RST_ZERO,
    pin_level: `IOL_RST_ZERO,
    waitreq: 1'b1,
    rdata: 32'h0000_0000,
    pad: '{out: `IOL_RST_ZERO, oe_n: `IOL_RST_ONES,
           pu_en: ~`IOL_RST_PULLUP, pd_en: ~`IOL_RST_PULLDOWN},
    fan: '{a: `IOL_RST_ZERO, b: `IOL_RST_ZERO, c: `IOL_RST_ZERO, d: `IOL_RST_ZERO}
  };

  iol_state_t st_reg;
  iol_state_t st_next;
  logic bus_busy;
  logic accept;
  logic wr_fire;
  logic [31:0] bm;
  iol_word_t wd;
  iol_word_t own_eff;
  iol_word_t lvl_w;
  iol_word_t en_w;
  logic [31:0] rd_word;
  logic [1:0] sel_i;

  ////////////////////////////////////////////////////////////////////////////
  // bus handshake: request seen, one wait cycle, then answer

  // waitrequest drops for exactly one cycle after a request is first seen
  assign bus_busy = avm_req.read | avm_req.write;
  assign accept = bus_busy & st_reg.waitreq;
  assign wr_fire = avm_req.write & ~st_reg.waitreq;
  assign bm = be_mask(avm_req.byteenable);
  assign wd = avm_req.writedata & bm;
  // lines without a peripheral always report controller ownership
  assign own_eff = st_reg.own | ~MUX_PRESENT;

  // read mux, write-only and unmapped offsets answer zero
  always_comb begin
    case (avm_req.address)
      `IOL_OFF_OWN_STATE: rd_word = own_eff;
      `IOL_OFF_DRIVE_STATE: rd_word = st_reg.drive;
      `IOL_OFF_LEVEL_VALUE: rd_word = st_reg.level;
      `IOL_OFF_PIN_LEVEL: rd_word = st_reg.pin_level;
      `IOL_OFF_OD_STATE: rd_word = st_reg.md;
      `IOL_OFF_PU_STATE: rd_word = st_reg.pu;
      `IOL_OFF_SEL_LOW: rd_word = st_reg.sel_lo;
      `IOL_OFF_SEL_HIGH: rd_word = st_reg.sel_hi;
      `IOL_OFF_PD_STATE: rd_word = st_reg.pd;
      `IOL_OFF_MASK_STATE: rd_word = st_reg.mask;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin mux per line, from current state

  // owner and select decide level and enable before open drain shaping
  always_comb begin
    lvl_w = '0;
    en_w = '0;
    sel_i = 2'b00;
    for (int i = 0; i < `IOL_NLINES; i++) begin
      sel_i = {st_reg.sel_hi[i], st_reg.sel_lo[i]};
      if (own_eff[i]) begin
        lvl_w[i] = st_reg.level[i];
        en_w[i] = st_reg.drive[i];
      end else begin
        lvl_w[i] = periph_drv[sel_i].out[i];
        en_w[i] = periph_drv[sel_i].oe[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_next = st_reg;
    // answer timing
    st_next.waitreq = ~accept;
    if (accept && avm_req.read) begin
      st_next.rdata = rd_word;
    end
    // register writes, not gated by line_clk_en; zero bits never act on set and clear offsets, but do on level value and select writes
    if (wr_fire) begin
      case (avm_req.address)
        `IOL_OFF_OWN_CLAIM: st_next.own = st_reg.own | (wd & MUX_PRESENT);
        `IOL_OFF_OWN_RELEASE: st_next.own = st_reg.own & ~(wd & MUX_PRESENT);
        // drive and level are kept whoever owns the line
        `IOL_OFF_DRIVE_ON: st_next.drive = st_reg.drive | wd;
        `IOL_OFF_DRIVE_OFF: st_next.drive = st_reg.drive & ~wd;
        `IOL_OFF_LEVEL_HIGH: st_next.level = st_reg.level | wd;
        `IOL_OFF_LEVEL_LOW: st_next.level = st_reg.level & ~wd;
        `IOL_OFF_LEVEL_VALUE: st_next.level = merge(st_reg.level, avm_req.writedata,
                                                    st_reg.mask & bm);
        `IOL_OFF_MASK_ON: st_next.mask = st_reg.mask | wd;
        `IOL_OFF_MASK_OFF: st_next.mask = st_reg.mask & ~wd;
        `IOL_OFF_OD_ON: st_next.md = st_reg.md | wd;
        `IOL_OFF_OD_OFF: st_next.md = st_reg.md & ~wd;
        // pulls: enabling one is dropped on lines where the other is on
        `IOL_OFF_PU_OFF: st_next.pu = st_reg.pu | wd;
        `IOL_OFF_PU_ON: st_next.pu = st_reg.pu & ~(wd & st_reg.pd);
        `IOL_OFF_PD_OFF: st_next.pd = st_reg.pd | wd;
        `IOL_OFF_PD_ON: st_next.pd = st_reg.pd & ~(wd & st_reg.pu);
        // selects are written whatever the owner
        `IOL_OFF_SEL_LOW: st_next.sel_lo = merge(st_reg.sel_lo, avm_req.writedata, bm);
        `IOL_OFF_SEL_HIGH: st_next.sel_hi = merge(st_reg.sel_hi, avm_req.writedata, bm);
        default: ;
      endcase
    end
    // pin input: two stages, then sampled only while the line clock runs
    st_next.sync1 = pad_in;
    st_next.sync2 = st_reg.sync1;
    if (line_clk_en) begin
      st_next.pin_level = st_reg.sync2;
    end
    // peripheral inputs see the pin whatever the select
    st_next.fan = '{a: st_reg.sync2, b: st_reg.sync2,
                    c: st_reg.sync2, d: st_reg.sync2};
    // open drain: drive only a low level, release for a high one
    st_next.pad.out = lvl_w & ~st_reg.md;
    st_next.pad.oe_n = ~(en_w & ~(st_reg.md & lvl_w));
    // pulls act on the pad for every owner
    st_next.pad.pu_en = ~st_reg.pu;
    st_next.pad.pd_en = ~st_reg.pd;
  end

  // single state register
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= RST_ST;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state register
  assign avm_rsp = '{readdata: st_reg.rdata, waitrequest: st_reg.waitreq};
  assign pad_drv = st_reg.pad;
  assign periph_in = st_reg.fan;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  iol_word_t pu_q;
  iol_word_t pd_q;
  iol_word_t own_q;
  iol_word_t level_q;
  iol_word_t mask_q;
  iol_word_t md_q;
  iol_word_t drive_q;
  iol_word_t pad_out_q;
  iol_word_t pad_oen_q;
  iol_word_t pad_pu_q;
  logic [7:0] addr_q;
  logic wr_pu_on;
  logic wr_pd_on;
  logic wr_pu_off;
  assign pu_q = st_reg.pu;
  assign pd_q = st_reg.pd;
  assign own_q = st_reg.own;
  assign level_q = st_reg.level;
  assign mask_q = st_reg.mask;
  assign md_q = st_reg.md;
  assign drive_q = st_reg.drive;
  assign pad_out_q = st_reg.pad.out;
  assign pad_oen_q = st_reg.pad.oe_n;
  assign pad_pu_q = st_reg.pad.pu_en;
  assign addr_q = avm_req.address;
  assign wr_pu_on = wr_fire && (addr_q == `IOL_OFF_PU_ON);
  assign wr_pd_on = wr_fire && (addr_q == `IOL_OFF_PD_ON);
  assign wr_pu_off = wr_fire && (addr_q == `IOL_OFF_PU_OFF);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  // handshake: one wait cycle, one ready cycle, then waiting again
  sequence s_taken;
    bus_busy && avm_rsp.waitrequest;
  endsequence
  sequence s_answer;
    ##1 !avm_rsp.waitrequest ##1 avm_rsp.waitrequest;
  endsequence
  property p_handshake;
    s_taken |-> s_answer;
  endproperty
  a_bus_handshake: assert property (p_handshake)
    else $error("waitrequest not low for exactly one cycle");

  // status lands first, the pad pull one edge later
  sequence s_pu_off_landed;
    ((pu_q & $past(wd)) == $past(wd)) ##1 ((pad_pu_q & $past(wd, 2)) == 32'h0000_0000);
  endsequence
  a_pullup_off_set: assert property (wr_pu_off |=> s_pu_off_landed)
    else $error("pull-up disable did not reach status and pad");

  a_pulldown_on_clr: assert property (
    wr_pd_on |=> ((pd_q & $past(wd) & $past(pu_q)) == 32'h0000_0000))
    else $error("pull-down enable did not clear status");

  a_pulldown_blocked: assert property (
    wr_pd_on |=> (((pd_q ^ $past(pd_q)) & ~$past(pu_q)) == 32'h0000_0000))
    else $error("pull-down enabled while pull-up on");

  a_pullup_blocked: assert property (
    wr_pu_on |=> (((pu_q ^ $past(pu_q)) & ~$past(pd_q)) == 32'h0000_0000))
    else $error("pull-up enabled while pull-down on");

  // the stored bit must not move, not only the forced read value
  a_fixed_owner: assert property (
    wr_fire && (addr_q == `IOL_OFF_OWN_RELEASE)
    |=> (((own_q ^ $past(own_q)) & ~MUX_PRESENT) == 32'h0000_0000)
    && ((own_eff & ~MUX_PRESENT) == ~MUX_PRESENT))
    else $error("unmuxed line lost controller ownership");

  a_masked_write: assert property (
    wr_fire && (addr_q == `IOL_OFF_LEVEL_VALUE)
    |=> (((level_q ^ $past(level_q)) & ~$past(mask_q)) == 32'h0000_0000))
    else $error("direct level write changed an unmasked bit");

  a_od_no_high: assert property (
    1'b1 |=> ((pad_out_q & $past(md_q)) == 32'h0000_0000)
    && ((~pad_oen_q & $past(md_q) & $past(lvl_w)) == 32'h0000_0000))
    else $error("open drain line driven high");

  // line 2 is the one handed to peripheral c, so this is reached
  a_periph_steer: assert property (
    !own_eff[2] && st_reg.sel_hi[2] && !st_reg.sel_lo[2] && !md_q[2]
    |=> (pad_out_q[2] == $past(periph_drv[2].out[2]))
    && (pad_oen_q[2] == !$past(periph_drv[2].oe[2])))
    else $error("released line not driven by peripheral c");

  a_read_back: assert property (
    accept && avm_req.read && (addr_q == `IOL_OFF_DRIVE_STATE)
    |=> (avm_rsp.readdata == $past(drive_q)) && !avm_rsp.waitrequest)
    else $error("drive status read back wrong");

  a_write_only: assert property (
    accept && avm_req.read && (addr_q == `IOL_OFF_DRIVE_ON)
    |=> (avm_rsp.readdata == 32'h0000_0000))
    else $error("set register read not zero");

  // line 2 is claimed and driven high, then low
  a_own_drive: assert property (
    own_eff[2] && drive_q[2] && !md_q[2]
    |=> !pad_oen_q[2] && (pad_out_q[2] == $past(level_q[2])))
    else $error("owned driven line not on the pad");

endmodule
`default_nettype wire

/* File: tb/iol_far_model.sv */
// far side model: four peripheral functions and the pad wires
`timescale 1ns/1ps
`default_nettype none

module iol_far_model import iol_pkg::*; (
  // clock
  input wire logic core_clk,
  // pad side
  input wire iol_pad_drv_t pad_drv,
  output var iol_word_t pad_in,
  // peripheral side
  output var iol_periph_drv_t [3:0] periph_drv
);

  logic tog_reg = 1'b0;

  //////////////////////////////////////////////////////////////////////////////
  // distinct pattern per peripheral so a wrong select shows at the pad
  always_comb begin
    periph_drv[0] = '{32'h0000_0000, 32'hFFFF_FFFF};
    periph_drv[1] = '{32'hFFFF_FFFF, 32'hFFFF_FFFF};
    periph_drv[2] = '{32'h0000_0000, 32'h0000_0000};
    periph_drv[3] = '{32'hFFFF_FFFF, 32'h0000_0000};
  end

  // a floating line with no pull wanders, so nobody may rely on it
  always_ff @(posedge core_clk) begin
    tog_reg <= ~tog_reg;
  end

  // wire level: own driver first, then the pulls
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      if (pad_drv.oe_n[i] == 1'b0) pad_in[i] = pad_drv.out[i];
      else if (pad_drv.pu_en[i]) pad_in[i] = 1'b1;
      else if (pad_drv.pd_en[i]) pad_in[i] = 1'b0;
      else pad_in[i] = tog_reg;
    end
  end

endmodule

`default_nettype wire

/* File: tb/test_iol_top.sv */
// self-checking bench for the io line output block
`timescale 1ns/1ps
`default_nettype none
`include "iol_map.svh"

module test_iol_top import iol_pkg::*;;

  localparam iol_word_t MUXP = 32'h7FFF_FFFF;
  localparam iol_word_t OWNR = 32'hFFFF_FFF0;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic line_clk_en = 1'b1;
  iol_avm_req_t avm_req = '0;
  iol_avm_rsp_t avm_rsp;
  iol_word_t pad_in;
  iol_pad_drv_t pad_drv;
  iol_periph_drv_t [3:0] periph_drv;
  iol_periph_in_t periph_in;
  int error_cnt = 0;
  int cmp_count = 0;
  logic [31:0] rd;

  // 40 MHz clock
  always #12.5 core_clk = ~core_clk;

  //////////////////////////////////////////////////////////////////////////////
  // line 31 has no peripheral, lines 0..3 leave reset peripheral-owned
  iol_top #(.MUX_PRESENT(MUXP), .OWN_RESET(OWNR)) dut_u (
    .core_clk(core_clk), .arst_n(arst_n), .avm_req(avm_req), .avm_rsp(avm_rsp),
    .line_clk_en(line_clk_en), .pad_in(pad_in), .pad_drv(pad_drv),
    .periph_drv(periph_drv), .periph_in(periph_in));

  iol_far_model far_u (.core_clk(core_clk), .pad_drv(pad_drv), .pad_in(pad_in),
    .periph_drv(periph_drv));

  //////////////////////////////////////////////////////////////////////////////
  task end_sim;
    $display("mismatches %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      error_cnt++;
    end
  endtask

  // one access; request held until waitrequest is seen low at an edge
  task bus(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    avm_req.address <= a;
    avm_req.writedata <= d;
    avm_req.byteenable <= 4'hF;
    avm_req.write <= wr_en;
    avm_req.read <= ~wr_en;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (avm_rsp.waitrequest !== 1'b0 && n < 40);
    rd = avm_rsp.readdata;
    avm_req.write <= 1'b0;
    avm_req.read <= 1'b0;
    if (n >= 40) begin
      $display("ERROR t=%0t waitrequest=%h exp=%h", $time, avm_rsp.waitrequest, 1'b0);
      error_cnt++;
      end_sim();
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  // pads follow one edge after state, pin inputs three edges after the pad
  task settle;
    repeat (5) @(posedge core_clk);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task t_reset;
    rdc(`IOL_OFF_PU_STATE, 32'h0);
    rdc(`IOL_OFF_PD_STATE, 32'hFFFF_FFFF);
    rdc(`IOL_OFF_OWN_STATE, OWNR);
    rdc(`IOL_OFF_SEL_LOW, 32'h0);
    rdc(`IOL_OFF_SEL_HIGH, 32'h0);
    rdc(`IOL_OFF_DRIVE_STATE, 32'h0);
    rdc(`IOL_OFF_LEVEL_VALUE, 32'h0);
    rdc(`IOL_OFF_MASK_STATE, 32'h0);
    rdc(`IOL_OFF_OD_STATE, 32'h0);
    chk(pad_drv.pu_en, 32'hFFFF_FFFF);
    chk(pad_drv.pd_en, 32'h0);
    rdc(`IOL_OFF_OWN_CLAIM, 32'h0);
    wr(8'hFC, 32'hFFFF_FFFF);
    rdc(8'hFC, 32'h0);
  endtask

  task t_pulls;
    wr(`IOL_OFF_PD_ON, 32'h1);
    rdc(`IOL_OFF_PD_STATE, 32'hFFFF_FFFF);
    wr(`IOL_OFF_PU_OFF, 32'h3);
    rdc(`IOL_OFF_PU_STATE, 32'h3);
    wr(`IOL_OFF_PD_ON, 32'h1);
    rdc(`IOL_OFF_PD_STATE, 32'hFFFF_FFFE);
    wr(`IOL_OFF_PU_ON, 32'h1);
    rdc(`IOL_OFF_PU_STATE, 32'h3);
    wr(`IOL_OFF_PU_OFF, 32'h0);
    rdc(`IOL_OFF_PU_STATE, 32'h3);
    settle();
    chk(pad_drv.pu_en, 32'hFFFF_FFFC);
    chk(pad_drv.pd_en, 32'h1);
    wr(`IOL_OFF_PD_OFF, 32'h1);
    wr(`IOL_OFF_PU_ON, 32'h3);
    rdc(`IOL_OFF_PU_STATE, 32'h0);
  endtask

  // software hands lines 0..3 to peripherals a, b, c, d
  task t_mux;
    wr(`IOL_OFF_SEL_LOW, 32'h1A);
    wr(`IOL_OFF_SEL_HIGH, 32'hC);
    wr(`IOL_OFF_OWN_RELEASE, 32'h8000_000F);
    rdc(`IOL_OFF_OWN_STATE, 32'hFFFF_FFF0);
    rdc(`IOL_OFF_SEL_LOW, 32'h1A);
    settle();
    chk(pad_drv.out & 32'hF, 32'hA);
    chk(pad_drv.oe_n & 32'hF, 32'hC);
    chk(periph_in.a & 32'hF, 32'hE);
    chk(periph_in.b & 32'hF, 32'hE);
    chk(periph_in.c & 32'hF, 32'hE);
    chk(periph_in.d & 32'hF, 32'hE);
    wr(`IOL_OFF_OWN_CLAIM, 32'h1);
    rdc(`IOL_OFF_OWN_STATE, 32'hFFFF_FFF1);
    settle();
    chk(pad_drv.oe_n & 32'hF, 32'hD);
    wr(`IOL_OFF_OWN_RELEASE, 32'h1);
  endtask

  task t_drive;
    wr(`IOL_OFF_DRIVE_ON, 32'h4);
    wr(`IOL_OFF_LEVEL_HIGH, 32'h4);
    rdc(`IOL_OFF_DRIVE_STATE, 32'h4);
    rdc(`IOL_OFF_DRIVE_ON, 32'h0);
    rdc(`IOL_OFF_LEVEL_VALUE, 32'h4);
    settle();
    chk(pad_drv.oe_n & 32'h4, 32'h4);
    wr(`IOL_OFF_OWN_CLAIM, 32'h4);
    settle();
    chk(pad_drv.out & 32'h4, 32'h4);
    chk(pad_drv.oe_n & 32'h4, 32'h0);
    wr(`IOL_OFF_LEVEL_LOW, 32'h4);
    settle();
    chk(pad_drv.out & 32'h4, 32'h0);
    wr(`IOL_OFF_DRIVE_OFF, 32'h4);
    settle();
    chk(pad_drv.oe_n & 32'h4, 32'h4);
    wr(`IOL_OFF_MASK_ON, 32'h30);
    rdc(`IOL_OFF_MASK_STATE, 32'h30);
    wr(`IOL_OFF_LEVEL_VALUE, 32'hFFFF_FFFF);
    rdc(`IOL_OFF_LEVEL_VALUE, 32'h30);
    wr(`IOL_OFF_MASK_OFF, 32'h10);
    rdc(`IOL_OFF_MASK_STATE, 32'h20);
    wr(`IOL_OFF_LEVEL_VALUE, 32'h0);
    rdc(`IOL_OFF_LEVEL_VALUE, 32'h10);
    wr(`IOL_OFF_OWN_RELEASE, 32'h4);
  endtask

  // line 4 is controller-owned at level one, line 1 is peripheral b
  task t_od;
    wr(`IOL_OFF_DRIVE_ON, 32'h10);
    wr(`IOL_OFF_OD_ON, 32'h12);
    rdc(`IOL_OFF_OD_STATE, 32'h12);
    settle();
    chk(pad_drv.out & 32'h12, 32'h0);
    chk(pad_drv.oe_n & 32'h12, 32'h12);
    wr(`IOL_OFF_LEVEL_LOW, 32'h10);
    settle();
    chk(pad_drv.oe_n & 32'h10, 32'h0);
    wr(`IOL_OFF_OD_OFF, 32'h12);
    rdc(`IOL_OFF_OD_STATE, 32'h0);
  endtask

  // all writes above ran with the line clock gated
  task t_pin;
    rdc(`IOL_OFF_PIN_LEVEL, 32'h0);
    line_clk_en <= 1'b1;
    settle();
    rdc(`IOL_OFF_PIN_LEVEL, 32'hFFFF_FFEE);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // reset for eight cycles, then the scenarios in turn
  initial begin
    repeat (8) @(posedge core_clk);
    arst_n <= 1'b1;
    line_clk_en <= 1'b0;
    t_reset();
    t_pulls();
    t_mux();
    t_drive();
    t_od();
    t_pin();
    end_sim();
  end

endmodule

`default_nettype wire
